// [shared/psfcc_defines.svh]
// Purpose: named constants for the power stage fault and clock control
// Assumes: included by the package and by every design file
// Notes:   offsets are word indexes on the plain register port
`ifndef PSFCC_DEFINES_SVH
`define PSFCC_DEFINES_SVH

// ****************************************************************
// register map
// ****************************************************************
`define PSFCC_A_STAGE    8'h00
`define PSFCC_A_PINEN    8'h01
`define PSFCC_A_RUN      8'h02
`define PSFCC_A_SYNC     8'h03
`define PSFCC_A_STAT     8'h04
`define PSFCC_OFS_W      3
`define PSFCC_MOD_BLK0   5'h02
`define PSFCC_O_SET_A    3'h0
`define PSFCC_O_RST_A    3'h1
`define PSFCC_O_SET_B    3'h2
`define PSFCC_O_RST_B    3'h3
`define PSFCC_O_INCTL    3'h4
`define PSFCC_O_MODCTL   3'h5

// ****************************************************************
// field positions
// ****************************************************************
`define PSFCC_F_CENTER   0
`define PSFCC_F_POL_A    1
`define PSFCC_F_POL_B    2
`define PSFCC_F_MODE     0
`define PSFCC_F_IN_POL   3
`define PSFCC_F_IN_FILT  4
`define PSFCC_F_IN_ASYNC 5
`define PSFCC_F_IN_LEVEL 6
`define PSFCC_F_CLK_SEL  0
`define PSFCC_F_PRE      1
`define PSFCC_F_OVL_DIS  3

// ****************************************************************
// codes and counts
// ****************************************************************
`define PSFCC_MODE_OFF   3'h0
`define PSFCC_MODE_A     3'h1
`define PSFCC_MODE_B     3'h2
`define PSFCC_MODE_AB    3'h3
`define PSFCC_MODE_ALL   2'h2
`define PSFCC_MODE_HALT  2'h3
`define PSFCC_SYNC_OFF   1
`define PSFCC_DIV1_LAST  8'h00
`define PSFCC_DIV4_LAST  8'h03
`define PSFCC_DIV32_LAST 8'h1F
`define PSFCC_DIV256_LAST 8'hFF
`define PSFCC_FILT_LEN   4

`endif

// [shared/psfcc_pkg.sv]
// Purpose: shared types of the power stage fault and clock control
// Assumes: constants come from the defines header
// Notes:   the top keeps its own parameterised state struct
`include "psfcc_defines.svh"

package psfcc_pkg;

  // counter direction of one module
  typedef enum logic {
    DIR_UP,
    DIR_DOWN
  } psfcc_dir_e;

  // state of one input conditioning slice
  typedef struct packed {
    logic [`PSFCC_FILT_LEN-1:0] smp;
    logic                       act;
    logic                       evt;
  } psfcc_in_s;

endpackage : psfcc_pkg

// [logic/psfcc_input.sv]
// Purpose: polarity, optional 4-tick filter and event detect of one input
// Assumes: i_tick is the one-cycle stage clock enable of the module
// Notes:   o_evt marks the start of the active condition
`timescale 1ns/1ps
`include "psfcc_defines.svh"

module psfcc_input
  import psfcc_pkg::*;
(
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  input  wire logic i_tick,
  input  wire logic i_raw,
  input  wire logic i_pol,
  input  wire logic i_filt_en,
  output logic      o_active,
  output logic      o_evt
);

  psfcc_in_s r;
  psfcc_in_s s;
  logic      lvl;

  always_comb begin
    s     = r;
    s.evt = 1'b0;
    lvl   = i_raw ~^ i_pol;
    if (i_tick) begin
      s.smp = {r.smp[`PSFCC_FILT_LEN-2:0], lvl};
      if (!i_filt_en) begin
        s.act = lvl;
      end else if (&s.smp) begin
        s.act = 1'b1;
      end else if (~|s.smp) begin
        s.act = 1'b0;
      end
      s.evt = s.act & ~r.act;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= s;
    end
  end

  assign o_active = r.act;
  assign o_evt    = r.evt;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_filt;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_filt_en && i_tick && (s.act != r.act) |=>
        (r.smp == {`PSFCC_FILT_LEN{r.act}});
  endproperty
  a_filt: assert property (p_filt)
    else $error("filter let through a glitch");

endmodule : psfcc_input

// [logic/psfcc_top.sv]
// Purpose: fault handling, overlap guard, adc sync and stage clock
// Assumes: clock enables of i/o and pll clock are synchronous pulses
// Notes:   registers on a plain port, read data one cycle later
//
// Function
// - overlap guard blocks A and B together
// - legacy variant guards only with both pins on
// - four 12-bit compares per module
// - each module owns one fault input
// - optional four stage-tick input filter
// - async kill bypasses the stage clock
// - polarity bit picks active edge or level
// - one-ramp: input acts over whole ramp
// - multi-ramp: A in phase 0, B phase 1
// - three-bit input mode decode
// - kill modes keep timing running
// - halt mode stops until run bit set
// - adc sync on chosen output edge
// - centered: reset-A times sync, keep nonzero
// - per-module irq: reload, input, sync error
// - input irq on edge or level start
// - clock select: i/o or pll
// - prescaler divides by 1, 4, 32, 256
// - pin follows port when drive disabled
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "psfcc_defines.svh"

module psfcc_top
  import psfcc_pkg::*;
#(
  parameter int   NMOD        = 3,
  parameter int   CW          = 12,
  parameter int   AW          = 8,
  parameter int   DW          = 16,
  parameter logic LEGACY_OVL  = 1'b0
) (
  input  wire logic            i_clk_sys,
  input  wire logic            i_rst_n,
  input  wire logic [AW-1:0]   i_addr,
  input  wire logic [DW-1:0]   i_wdata,
  input  wire logic            i_wr_stb,
  input  wire logic            i_rd_stb,
  output logic      [DW-1:0]   o_rdata,
  input  wire logic            i_io_clk_en,
  input  wire logic            i_pll_clk_en,
  input  wire logic [NMOD-1:0] i_fault_input,
  input  wire logic [NMOD-1:0] i_port_a,
  input  wire logic [NMOD-1:0] i_port_b,
  output logic      [NMOD-1:0] o_gate_out_a,
  output logic      [NMOD-1:0] o_gate_out_b,
  output logic      [NMOD-1:0] o_adc_sync_strobe,
  output logic      [NMOD-1:0] o_module_irq
);

  typedef struct packed {
    logic [NMOD-1:0][CW-1:0] set_a;
    logic [NMOD-1:0][CW-1:0] rst_a;
    logic [NMOD-1:0][CW-1:0] set_b;
    logic [NMOD-1:0][CW-1:0] rst_b;
    logic [NMOD-1:0][6:0]    inctl;
    logic [NMOD-1:0][3:0]    modctl;
    logic [2:0]              stage;
    logic [2*NMOD-1:0]       pin_en;
    logic [NMOD-1:0]         run;
    logic [2*NMOD-1:0]       sync_sel;
    logic [NMOD-1:0][7:0]    pre;
    logic [NMOD-1:0][CW-1:0] cnt;
    psfcc_dir_e [NMOD-1:0]   dir;
    logic [NMOD-1:0]         kill_a_l;
    logic [NMOD-1:0]         kill_b_l;
    logic [NMOD-1:0]         kill_all_l;
    logic [NMOD-1:0]         act_a;
    logic [NMOD-1:0]         act_b;
    logic [NMOD-1:0]         gate_a;
    logic [NMOD-1:0]         gate_b;
    logic [NMOD-1:0]         sync;
    logic [NMOD-1:0]         irq;
    logic [DW-1:0]           rdata;
  } psfcc_state_s;

  psfcc_state_s r;
  psfcc_state_s s;

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic [7:0] div_last(input logic [1:0] sel);
    case (sel)
      2'h0:    div_last = `PSFCC_DIV1_LAST;
      2'h1:    div_last = `PSFCC_DIV4_LAST;
      2'h2:    div_last = `PSFCC_DIV32_LAST;
      default: div_last = `PSFCC_DIV256_LAST;
    endcase
  endfunction : div_last

  // bit 0 kills A, bit 1 kills B of the own module
  function automatic logic [1:0] mode_kill(input logic [2:0] mode);
    case (mode)
      `PSFCC_MODE_OFF: mode_kill = 2'h0;
      `PSFCC_MODE_A:   mode_kill = 2'h1;
      `PSFCC_MODE_B:   mode_kill = 2'h2;
      default:         mode_kill = 2'h3;
    endcase
  endfunction : mode_kill

  function automatic logic mod_hit(input logic [AW-1:0] a, input int n);
    mod_hit = a[AW-1:`PSFCC_OFS_W] ==
              (AW-`PSFCC_OFS_W)'(`PSFCC_MOD_BLK0 + n);
  endfunction : mod_hit

  // ****************************************************************
  // per-module clocking, waveform windows and inputs
  // ****************************************************************
  logic [NMOD-1:0] src;
  logic [NMOD-1:0] tick;
  logic [NMOD-1:0] raw_act;
  logic [NMOD-1:0] flt_act;
  logic [NMOD-1:0] flt_evt;
  logic [NMOD-1:0] reload;
  logic [NMOD-1:0] wave_a;
  logic [NMOD-1:0] wave_b;
  logic [NMOD-1:0] win_a;
  logic [NMOD-1:0] win_b;
  logic [NMOD-1:0] trig;
  logic            center;

  assign center = r.stage[`PSFCC_F_CENTER];

  for (genvar g = 0; g < NMOD; g++) begin : g_mod
    assign src[g]  = r.modctl[g][`PSFCC_F_CLK_SEL] ? i_pll_clk_en
                                                   : i_io_clk_en;
    assign tick[g] = src[g] &&
                     (r.pre[g] ==
                      div_last(r.modctl[g][`PSFCC_F_PRE +: 2]));
    assign raw_act[g] = i_fault_input[g] ~^ r.inctl[g][`PSFCC_F_IN_POL];
    assign reload[g]  = r.run[g] && tick[g] && (r.dir[g] == DIR_UP) &&
                        (r.cnt[g] >= r.rst_b[g]);
    assign wave_a[g]  = center ? (r.cnt[g] < r.set_a[g])
                               : (r.cnt[g] >= r.set_a[g]) &&
                                 (r.cnt[g] < r.rst_a[g]);
    assign wave_b[g]  = center ? (r.cnt[g] >= r.set_b[g])
                               : (r.cnt[g] >= r.set_b[g]) &&
                                 (r.cnt[g] < r.rst_b[g]);
    // phase 0 lasts until set-B is reached
    assign win_a[g] = !center || (r.cnt[g] <  r.set_b[g]);
    assign win_b[g] = !center || (r.cnt[g] >= r.set_b[g]);
    assign trig[g]  = r.inctl[g][`PSFCC_F_IN_LEVEL] ? flt_act[g]
                                                     : flt_evt[g];

    psfcc_input u_in (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_tick    (tick[g]),
      .i_raw     (i_fault_input[g]),
      .i_pol     (r.inctl[g][`PSFCC_F_IN_POL]),
      .i_filt_en (r.inctl[g][`PSFCC_F_IN_FILT]),
      .o_active  (flt_act[g]),
      .o_evt     (flt_evt[g])
    );
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  logic [NMOD-1:0] ka;
  logic [NMOD-1:0] kb;
  logic [NMOD-1:0] na;
  logic [NMOD-1:0] nb;
  logic            all_kill;
  logic [1:0]      km;
  logic [2:0]      md;
  logic            lvl;
  logic            prot;

  always_comb begin
    s        = r;
    s.sync   = '0;
    s.irq    = '0;
    s.rdata  = '0;
    ka       = '0;
    kb       = '0;
    na       = '0;
    nb       = '0;
    all_kill = 1'b0;
    km       = 2'h0;
    md       = 3'h0;
    lvl      = 1'b0;
    prot     = 1'b0;

    // register writes
    if (i_wr_stb) begin
      case (i_addr)
        `PSFCC_A_STAGE: s.stage    = i_wdata[2:0];
        `PSFCC_A_PINEN: s.pin_en   = i_wdata[2*NMOD-1:0];
        `PSFCC_A_RUN:   s.run      = i_wdata[NMOD-1:0];
        `PSFCC_A_SYNC:  s.sync_sel = i_wdata[2*NMOD-1:0];
        default: begin
          for (int n = 0; n < NMOD; n++) begin
            if (mod_hit(i_addr, n)) begin
              case (i_addr[`PSFCC_OFS_W-1:0])
                `PSFCC_O_SET_A:  s.set_a[n]  = i_wdata[CW-1:0];
                `PSFCC_O_RST_A:  s.rst_a[n]  = i_wdata[CW-1:0];
                `PSFCC_O_SET_B:  s.set_b[n]  = i_wdata[CW-1:0];
                `PSFCC_O_RST_B:  s.rst_b[n]  = i_wdata[CW-1:0];
                `PSFCC_O_INCTL:  s.inctl[n]  = i_wdata[6:0];
                `PSFCC_O_MODCTL: s.modctl[n] = i_wdata[3:0];
                default: ;
              endcase
            end
          end
        end
      endcase
    end

    // register reads, data valid in the following cycle only
    if (i_rd_stb) begin
      case (i_addr)
        `PSFCC_A_STAGE: s.rdata = DW'(r.stage);
        `PSFCC_A_PINEN: s.rdata = DW'(r.pin_en);
        `PSFCC_A_RUN:   s.rdata = DW'(r.run);
        `PSFCC_A_SYNC:  s.rdata = DW'(r.sync_sel);
        `PSFCC_A_STAT:  s.rdata = DW'({r.act_b, r.act_a, flt_act});
        default: begin
          for (int n = 0; n < NMOD; n++) begin
            if (mod_hit(i_addr, n)) begin
              case (i_addr[`PSFCC_OFS_W-1:0])
                `PSFCC_O_SET_A:  s.rdata = DW'(r.set_a[n]);
                `PSFCC_O_RST_A:  s.rdata = DW'(r.rst_a[n]);
                `PSFCC_O_SET_B:  s.rdata = DW'(r.set_b[n]);
                `PSFCC_O_RST_B:  s.rdata = DW'(r.rst_b[n]);
                `PSFCC_O_INCTL:  s.rdata = DW'(r.inctl[n]);
                `PSFCC_O_MODCTL: s.rdata = DW'(r.modctl[n]);
                default:         s.rdata = '0;
              endcase
            end
          end
        end
      endcase
    end

    // prescaler, counter, fault latches
    for (int n = 0; n < NMOD; n++) begin
      md  = r.inctl[n][`PSFCC_F_MODE +: 3];
      lvl = r.inctl[n][`PSFCC_F_IN_LEVEL];
      km  = mode_kill(md);
      if (src[n]) begin
        s.pre[n] = tick[n] ? '0 : 8'(r.pre[n] + 8'h01);
      end
      // counter stops only through the run bit, never through a kill
      if (!r.run[n]) begin
        s.cnt[n] = '0;
        s.dir[n] = DIR_UP;
      end else if (tick[n]) begin
        if (reload[n]) begin
          s.cnt[n] = center ? r.cnt[n] : '0;
          s.dir[n] = center ? DIR_DOWN : DIR_UP;
        end else if (r.dir[n] == DIR_DOWN) begin
          if (r.cnt[n] == '0) begin
            s.dir[n] = DIR_UP;
          end else begin
            s.cnt[n] = CW'(r.cnt[n] - 1'b1);
          end
        end else begin
          s.cnt[n] = CW'(r.cnt[n] + 1'b1);
        end
      end
      // edge modes hold the kill to the end of the cycle; set wins
      if (reload[n]) begin
        s.kill_a_l[n]   = 1'b0;
        s.kill_b_l[n]   = 1'b0;
        s.kill_all_l[n] = 1'b0;
      end
      if (!lvl && md[2] == 1'b0) begin
        if (flt_evt[n] && win_a[n] && km[0]) s.kill_a_l[n] = 1'b1;
        if (flt_evt[n] && win_b[n] && km[1]) s.kill_b_l[n] = 1'b1;
      end
      if (!lvl && md[2:1] == `PSFCC_MODE_ALL && flt_evt[n]) begin
        s.kill_all_l[n] = 1'b1;
      end
      if (md[2:1] == `PSFCC_MODE_ALL && (s.kill_all_l[n] ||
          (lvl && flt_act[n]))) begin
        all_kill = 1'b1;
      end
      if (md[2:1] == `PSFCC_MODE_HALT && trig[n]) begin
        s.run[n] = 1'b0;
      end
      ka[n] = s.kill_a_l[n] ||
              (lvl && flt_act[n] && win_a[n] && km[0] && !md[2]);
      kb[n] = s.kill_b_l[n] ||
              (lvl && flt_act[n] && win_b[n] && km[1] && !md[2]);
      // raw level path: acts even while no stage tick arrives
      if (r.inctl[n][`PSFCC_F_IN_ASYNC] && raw_act[n] &&
          md != `PSFCC_MODE_OFF) begin
        ka[n] = 1'b1;
        kb[n] = 1'b1;
      end
      // irq sources: reload, input event, sync error against module 0
      s.irq[n] = reload[n] ||
                 (flt_evt[n] && md != `PSFCC_MODE_OFF) ||
                 (n != 0 && reload[n] && r.run[0] && !reload[0] &&
                  r.modctl[n][2:0] == r.modctl[0][2:0]);
    end

    // outputs, overlap guard, pin mux, adc sync
    for (int n = 0; n < NMOD; n++) begin
      na[n] = r.run[n] && wave_a[n] && !ka[n] && !all_kill;
      nb[n] = r.run[n] && wave_b[n] && !kb[n] && !all_kill;
      prot  = !r.modctl[n][`PSFCC_F_OVL_DIS] &&
              (!LEGACY_OVL || (r.pin_en[2*n] && r.pin_en[2*n+1]));
      if (prot && na[n] && nb[n]) begin
        na[n] = 1'b0;
        nb[n] = 1'b0;
      end
      s.act_a[n]  = na[n];
      s.act_b[n]  = nb[n];
      s.gate_a[n] = r.pin_en[2*n] ?
                    (na[n] ~^ r.stage[`PSFCC_F_POL_A]) : i_port_a[n];
      s.gate_b[n] = r.pin_en[2*n+1] ?
                    (nb[n] ~^ r.stage[`PSFCC_F_POL_B]) : i_port_b[n];
      if (!center) begin
        case (r.sync_sel[2*n +: 2])
          2'h0:    s.sync[n] =  na[n] && !r.act_a[n];
          2'h1:    s.sync[n] = !na[n] &&  r.act_a[n];
          2'h2:    s.sync[n] =  nb[n] && !r.act_b[n];
          default: s.sync[n] = !nb[n] &&  r.act_b[n];
        endcase
      end else if (!r.sync_sel[2*n+`PSFCC_SYNC_OFF]) begin
        s.sync[n] = r.run[n] && tick[n] && r.rst_a[n] != '0 &&
                    r.cnt[n] == r.rst_a[n] &&
                    (r.dir[n] == (r.sync_sel[2*n] ? DIR_UP : DIR_DOWN));
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= s;
    end
  end

  assign o_rdata           = r.rdata;
  assign o_gate_out_a      = r.gate_a;
  assign o_gate_out_b      = r.gate_b;
  assign o_adc_sync_strobe = r.sync;
  assign o_module_irq      = r.irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  for (genvar g = 0; g < NMOD; g++) begin : g_chk
    sequence s_lead_a;
      !r.act_a[g] && !center && r.sync_sel[2*g +: 2] == 2'h0;
    endsequence

    property p_overlap;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
        !r.modctl[g][`PSFCC_F_OVL_DIS] &&
        (!LEGACY_OVL || (r.pin_en[2*g] && r.pin_en[2*g+1]))
        |=> !(r.act_a[g] && r.act_b[g]);
    endproperty
    a_overlap: assert property (p_overlap) else $error("A and B overlap");

    property p_halt;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
        trig[g] && r.inctl[g][2:1] == `PSFCC_MODE_HALT |=> !r.run[g];
    endproperty
    a_halt: assert property (p_halt) else $error("halt did not stop");

    property p_restart;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_wr_stb && i_addr == `PSFCC_A_RUN && i_wdata[g] &&
        !(trig[g] && r.inctl[g][2:1] == `PSFCC_MODE_HALT) |=> r.run[g];
    endproperty
    a_restart: assert property (p_restart) else $error("run not set");

    property p_kill_all;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
        r.inctl[g][`PSFCC_F_IN_LEVEL] && flt_act[g] &&
        r.inctl[g][2:1] == `PSFCC_MODE_ALL |=>
        (r.act_a == '0) && (r.act_b == '0);
    endproperty
    a_kill_all: assert property (p_kill_all) else $error("outputs alive");

    property p_async;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
        r.inctl[g][`PSFCC_F_IN_ASYNC] && raw_act[g] &&
        r.inctl[g][2:0] != `PSFCC_MODE_OFF |=> !r.act_a[g] && !r.act_b[g];
    endproperty
    a_async: assert property (p_async) else $error("async kill missed");

    property p_pin;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
        !r.pin_en[2*g] |=> o_gate_out_a[g] == $past(i_port_a[g]);
    endproperty
    a_pin: assert property (p_pin) else $error("port value not passed");

    property p_sync;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
        s_lead_a ##1 r.act_a[g] |-> o_adc_sync_strobe[g];
    endproperty
    a_sync: assert property (p_sync) else $error("adc sync missing");

    property p_irq;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
        reload[g] |=> o_module_irq[g] && (r.cnt[g] == '0 || $past(center));
    endproperty
    a_irq: assert property (p_irq) else $error("reload irq missing");
  end

endmodule : psfcc_top

// [verification/psfcc_partner.sv]
// Purpose: fault sensor model beside the power stage
// Assumes: trip request comes from the bench, active high
// Notes:   slow mode answers three cycles late
`timescale 1ns/1ps

module psfcc_partner
  import psfcc_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire logic [2:0] i_trip,
  input  wire logic       i_slow,
  output logic      [2:0] o_fault
);
  // ****
  // sensor delay line
  // ****
  logic [8:0] dly_r;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      dly_r <= 9'h000;
    end else begin
      dly_r <= {dly_r[5:0], i_trip};
    end
  end

  // one sensor line per module, reports high when tripped
  assign o_fault = i_slow ? dly_r[8:6] : i_trip;
endmodule : psfcc_partner

// [verification/tb_top.sv]
// Purpose: self-checking bench of the fault and clock control
// Assumes: modules 0 and 1 run with active-high pins, one-ramp except in t_center
// Notes:   windows of whole periods (four, or two when centered) count periodic events exactly
`timescale 1ns/1ps

module tb_top
  import psfcc_pkg::*;
;
  logic        clk_sys, rst_n, wr_stb, rd_stb, io_en, pll_en, slow;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, d;
  logic [2:0]  trip, fault, port_a, port_b, ga, gb, sync, irq;
  logic        s_a0, s_b0, s_a1, s_ab;
  int          error_cnt, n_tests, n_irq, n_sync;

  psfcc_top DUT (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr_stb(wr_stb), .i_rd_stb(rd_stb), .o_rdata(rdata),
    .i_io_clk_en(io_en), .i_pll_clk_en(pll_en), .i_fault_input(fault),
    .i_port_a(port_a), .i_port_b(port_b), .o_gate_out_a(ga),
    .o_gate_out_b(gb), .o_adc_sync_strobe(sync), .o_module_irq(irq));
  psfcc_partner u_sens (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
    .i_trip(trip), .i_slow(slow), .o_fault(fault));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // pll enable every other cycle, so pll rate is half the i/o rate
  always @(posedge clk_sys) pll_en <= ~pll_en;

  // ****
  // shared tasks
  // ****
  task automatic final_report();
    $display("tests %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", what, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    addr <= a; wdata <= v; wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    addr <= a; rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    @(negedge clk_sys);
    v = rdata;
  endtask : rd
  task automatic cmp4(input logic [7:0] b, input logic [11:0] ra);
    wr(b, 16'h0001); wr(b + 8'h01, {4'h0, ra});
    wr(b + 8'h02, 16'h0003); wr(b + 8'h03, 16'h0006);
  endtask : cmp4
  task automatic observe(input int n);
    {s_a0, s_b0, s_a1, s_ab} = 4'h0; n_irq = 0; n_sync = 0;
    repeat (n) begin
      @(negedge clk_sys);
      s_a0 |= ga[0] === 1'b1; s_b0 |= gb[0] === 1'b1;
      s_a1 |= ga[1] === 1'b1; s_ab |= ga[0] === 1'b1 && gb[0] === 1'b1;
      n_irq += irq[0] === 1'b1; n_sync += sync[0] === 1'b1;
    end
  endtask : observe
  task automatic wait_irq(output int c);
    c = 0;
    do begin
      @(negedge clk_sys);
      c++;
      if (c > 4000) begin
        error_cnt++;
        final_report();
      end
    end while (irq[0] !== 1'b1);
  endtask : wait_irq

  // ****
  // scenarios
  // ****
  task automatic t_regs();
    repeat (2) @(negedge clk_sys);
    chk("pin a follows port", 16'(port_a), 16'(ga));
    chk("pin b follows port", 16'(port_b), 16'(gb));
    wr(8'h10, 16'hFFFF); rd(8'h10, d);
    chk("compare width", 16'h0FFF, d);
    rd(8'h0F, d);
    chk("unmapped read", 16'h0000, d);
    wr(8'h00, 16'h0006); wr(8'h01, 16'h000F);
    cmp4(8'h10, 12'h003); cmp4(8'h18, 12'h003);
    wr(8'h02, 16'h0003);
    $display("test regs done");
  endtask : t_regs
  task automatic t_clock();
    logic [15:0] ctl [6] = '{16'h0, 16'h2, 16'h4, 16'h6, 16'h1, 16'h3};
    int          per [6] = '{7, 28, 224, 1792, 14, 56};
    int          c;
    foreach (ctl[i]) begin
      wr(8'h15, ctl[i]);
      wait_irq(c); wait_irq(c);
      chk("reload period", 16'(per[i]), 16'(c));
    end
    wr(8'h15, 16'h0000);
    // prescaler may run once round its 8 bits after a divider change
    wait_irq(c);
    $display("test clock done");
  endtask : t_clock
  task automatic t_overlap();
    cmp4(8'h10, 12'h005);
    observe(28);
    chk("overlap guarded", 16'h0, 16'(s_ab));
    wr(8'h15, 16'h0008);
    observe(28);
    chk("overlap free", 16'h1, 16'(s_ab));
    wr(8'h15, 16'h0000); cmp4(8'h10, 12'h003);
    $display("test overlap done");
  endtask : t_overlap
  task automatic t_modes();
    logic [7:0] ctl [7] = '{8'h48, 8'h49, 8'h5A, 8'h6B, 8'h4C, 8'h4E, 8'h43};
    logic [2:0] ex  [7] = '{3'h7, 3'h3, 3'h5, 3'h1, 3'h0, 3'h1, 3'h7};
    foreach (ctl[i]) begin
      wr(8'h14, {8'h00, ctl[i]});
      slow <= i[0];
      trip <= 3'b001;
      repeat (8) @(posedge clk_sys);
      observe(28);
      chk("pins under input", 16'(ex[i]), 16'({s_a0, s_b0, s_a1}));
      chk("reloads", (i == 5) ? 16'h0 : 16'h4, 16'(n_irq));
      if (i == 0) chk("adc sync count", 16'h4, 16'(n_sync));
      @(posedge clk_sys) trip <= 3'b000;
      repeat (3) @(posedge clk_sys);
      if (i == 5) begin
        rd(8'h02, d);
        chk("halted run bits", 16'h0002, d);
        wr(8'h02, 16'h0003);
      end
      wr(8'h14, 16'h0000);
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_center();
    int c;
    wr(8'h00, 16'h0007);
    wait_irq(c); wait_irq(c);
    chk("centered period", 16'h000E, 16'(c));
    observe(28);
    chk("centered reloads", 16'h2, 16'(n_irq));
    chk("centered sync", 16'h2, 16'(n_sync));
    chk("centered pins", 16'h3, 16'({s_a0, s_b0}));
    $display("test center done");
  endtask : t_center

  initial begin
    rst_n = 1'b0; wr_stb = 1'b0; rd_stb = 1'b0; addr = 8'h00;
    wdata = 16'h0000; io_en = 1'b1; pll_en = 1'b0; trip = 3'b000;
    slow = 1'b0; port_a = 3'b101; port_b = 3'b010;
    error_cnt = 0; n_tests = 0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs(); t_clock(); t_overlap(); t_modes(); t_center();
    final_report();
  end
endmodule : tb_top
